// [cca_defs.vh]
// constants for the counter-array capture/compare mode block
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// ============================================================
// mode register addresses on the special-function-register bus
`define CCA_MODE0_ADDR      8'hDA
`define CCA_MODE1_ADDR      8'hDB
`define CCA_MODE2_ADDR      8'hDC
`define CCA_MODE3_ADDR      8'hDD
`define CCA_MODE4_ADDR      8'hDE

// ============================================================
// mode register reset value
`define CCA_MODE_RESET      8'h00

// ============================================================
// mode register field positions
`define CCA_WIDE_MOD_BIT    7
`define CCA_CMP_EN_BIT      6
`define CCA_RISE_CAP_BIT    5
`define CCA_FALL_CAP_BIT    4
`define CCA_MATCH_EN_BIT    3
`define CCA_TOGGLE_EN_BIT   2
`define CCA_MOD_EN_BIT      1
`define CCA_IRQ_EN_BIT      0

// ============================================================
// function field (match, toggle, modulation) patterns per mode
`define CCA_FN_CAPTURE      3'h0
`define CCA_FN_SW_TIMER     3'h4
`define CCA_FN_HS_OUTPUT    3'h6
`define CCA_FN_FREQ_OUTPUT  3'h3

// ============================================================
// other reset values
`define CCA_CCR_RESET       16'h0000
`define CCA_RDATA_RESET     8'h00

`endif

// [cca_pin_sync.v]
// two-flop synchroniser and edge detector for the module pins
`timescale 1ns/1ns

module cca_pin_sync
#(
	parameter WIDTH = 5
)
(
	// clock and reset
	input  wire             ref_clk,
	input  wire             reset,
	// raw pins
	input  wire [WIDTH-1:0] pinIn,
	// synchronised edges
	output wire [WIDTH-1:0] riseEdge,
	output wire [WIDTH-1:0] fallEdge
);

	// ============================================================
	// synchroniser chain
	reg [WIDTH-1:0] syncFirst;
	reg [WIDTH-1:0] syncSecond;
	reg [WIDTH-1:0] syncLast;

	// first stage is read only by the second stage
	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			syncFirst  <= {WIDTH{1'b0}};
			syncSecond <= {WIDTH{1'b0}};
			syncLast   <= {WIDTH{1'b0}};
		end
		else
		begin
			syncFirst  <= pinIn;
			syncSecond <= syncFirst;
			syncLast   <= syncSecond;
		end
	end

	// ============================================================
	// one pulse per transition
	assign riseEdge = syncSecond & ~syncLast; // R17
	assign fallEdge = ~syncSecond & syncLast; // R17

endmodule

// [cca_mode_select.v]
// five capture/compare modules of the counter array with their mode registers
// Overview of operation
// (R01) five modules, each with its own mode
// (R02) rise bit alone: capture on rising edges
// (R03) fall bit alone: capture on falling edges
// (R04) both capture bits: capture every transition
// (R05) function bits pick timer, fast output, frequency
// (R06) modulation bit; wide bit picks 8/16 bits
// (R07) modulation with match bit sets flag
// (R08) irq enable passes flag as request
// (R09) comparator off: no pin toggling
// (R10) comparator off in modulation: pin low
// (R11) don't care bits have no effect
// (R12) five reset-zero mode registers, consecutive addresses
// (R13) match enabled: equality sets the flag
// (R14) toggle enabled: match inverts the pin
// (R15) irq enable clear: no request
// (R16) capture copies counter and sets flag
// (R17) pin synchronised before edge detection
`timescale 1ns/1ns
`include "cca_defs.vh"

module cca_mode_select
#(
	parameter NUM_MODULES = 5,
	parameter CNT_WIDTH   = 16
)
(
	// clock and reset
	input  wire                           ref_clk,
	input  wire                           reset,
	// special-function-register bus
	input  wire [7:0]                     sfrAddr,
	input  wire                           sfrWrite,
	input  wire                           sfrRead,
	input  wire [7:0]                     sfrWdata,
	output reg  [7:0]                     sfrRdata,
	// shared time base
	input  wire [CNT_WIDTH-1:0]           counterValue,
	// capture/compare register load from software
	input  wire [NUM_MODULES-1:0]         ccLoad,
	input  wire [CNT_WIDTH-1:0]           ccLoadData,
	output wire [NUM_MODULES*CNT_WIDTH-1:0] ccValue,
	// flags and interrupt requests
	input  wire [NUM_MODULES-1:0]         flagClear,
	output wire [NUM_MODULES-1:0]         captureCompareFlag,
	output wire [NUM_MODULES-1:0]         irqRequest,
	// module pins
	input  wire [NUM_MODULES-1:0]         modulePinIn,
	output wire [NUM_MODULES-1:0]         modulePinOut,
	output wire [NUM_MODULES-1:0]         modulePinOeN
);

	// ============================================================
	// pin synchronisation
	// pins are asynchronous; two flops before any edge is looked at
	wire [NUM_MODULES-1:0] pinRise;
	wire [NUM_MODULES-1:0] pinFall;

	cca_pin_sync
	#(
		.WIDTH (NUM_MODULES)
	)
	uPinSync
	(
		.ref_clk  (ref_clk),
		.reset    (reset),
		.pinIn    (modulePinIn),
		.riseEdge (pinRise),
		.fallEdge (pinFall)
	);

	// ============================================================
	// flat copies of each module's mode register for readback
	wire [NUM_MODULES*8-1:0] modeFlat;

	// ============================================================
	// register readback
	reg [7:0] next_sfrRdata;
	integer   rdIdx;

	// unmapped addresses read as zero
	// registered so the byte stands until the next read strobe
	always @*
	begin
		next_sfrRdata = `CCA_RDATA_RESET;
		for (rdIdx = 0; rdIdx < NUM_MODULES; rdIdx = rdIdx + 1)
		begin
			if (sfrAddr == `CCA_MODE0_ADDR + rdIdx[7:0])
			begin
				next_sfrRdata = modeFlat[rdIdx*8 +: 8]; // R12
			end
		end
	end

	always @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sfrRdata <= `CCA_RDATA_RESET;
		end
		else if (sfrRead)
		begin
			sfrRdata <= next_sfrRdata;
		end
	end

	// ============================================================
	// per-module logic
	genvar ch;
	generate
		for (ch = 0; ch < NUM_MODULES; ch = ch + 1)
		begin : gModule
			reg  [7:0]           mode;
			reg  [CNT_WIDTH-1:0] ccr;
			reg                  flag;
			reg                  irq;
			reg                  pinLevel;
			reg                  next_pinLevel;
			reg                  pinOeN;
			reg                  eqPrev;

			// genvar is 32 bits wide; only its low byte offsets the address
			wire [31:0] chOffset = ch;
			wire [7:0]  myAddr   = `CCA_MODE0_ADDR + chOffset[7:0];
			wire       modeHit = sfrWrite && (sfrAddr == myAddr);

			// field decode
			wire       cmpOn   = mode[`CCA_CMP_EN_BIT];
			wire       riseOn  = mode[`CCA_RISE_CAP_BIT];
			wire       fallOn  = mode[`CCA_FALL_CAP_BIT];
			wire       matchOn = mode[`CCA_MATCH_EN_BIT];
			wire       wideOn  = mode[`CCA_WIDE_MOD_BIT];
			wire       irqOn   = mode[`CCA_IRQ_EN_BIT];
			wire [2:0] fnBits  = mode[`CCA_MATCH_EN_BIT:`CCA_MOD_EN_BIT];
			wire       capBits = riseOn | fallOn;

			// mode decode; bits outside a mode's pattern are not looked at
			wire isCapture = capBits && (fnBits == `CCA_FN_CAPTURE); // R02 R03 R04
			wire isTimer   = !capBits && (fnBits == `CCA_FN_SW_TIMER); // R05
			wire isFastOut = !capBits && (fnBits == `CCA_FN_HS_OUTPUT); // R05
			wire isFreqOut = !capBits && (fnBits == `CCA_FN_FREQ_OUTPUT); // R05
			wire isModul   = !capBits && !mode[`CCA_TOGGLE_EN_BIT]
				&& mode[`CCA_MOD_EN_BIT]; // R06
			wire isMod8    = isModul && !wideOn; // R06
			wire isMod16   = isModul && wideOn; // R06

			// modes in which the module owns its pin
			wire toggleMode = isFastOut || isFreqOut;
			wire outMode    = toggleMode || isModul;

			// comparison width: 8-bit modulation and frequency use the low byte
			wire narrowCmp = isMod8 || isFreqOut;
			wire eqNow     = narrowCmp ? (counterValue[7:0] == ccr[7:0])
				: (counterValue == ccr);
			// one match per counter value even if the counter dwells
			wire matchEvt  = cmpOn && eqNow && !eqPrev; // R09
			// all ones in the compared width ends the modulation period
			wire rollNow   = isMod8 ? (counterValue[7:0] == 8'hFF)
				: (counterValue == {CNT_WIDTH{1'b1}});

			// capture edge qualification, comparator bit is ignored here
			wire capEvt = isCapture &&
				((riseOn && pinRise[ch]) || (fallOn && pinFall[ch])); // R02 R03 R04 R11

			// flag set sources
			wire setTimer = (isTimer || isFastOut) && matchEvt; // R13
			wire setModul = isModul && matchOn && matchEvt; // R07
			wire flagSet  = capEvt || setTimer || setModul; // R16

			wire next_flag = flagSet | (flag & ~flagClear[ch]);

			// mode register, software side
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					mode <= `CCA_MODE_RESET; // R12
				end
				else if (modeHit)
				begin
					mode <= sfrWdata; // R01 R12
				end
			end

			// capture/compare register
			// a capture edge beats a software load in the same cycle
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					ccr <= `CCA_CCR_RESET;
				end
				else if (capEvt)
				begin
					ccr <= counterValue; // R16
				end
				else if (ccLoad[ch])
				begin
					ccr <= ccLoadData;
				end
			end

			// flag; a set in the clear cycle wins
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					flag <= 1'b0;
				end
				else
				begin
					flag <= next_flag; // R13 R16
				end
			end

			// request follows the next flag value so it rises with the flag
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					irq <= 1'b0;
				end
				else
				begin
					irq <= next_flag & irqOn; // R08 R15
				end
			end

			// equality history, so a dwelling counter matches only once
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					eqPrev <= 1'b0;
				end
				else
				begin
					eqPrev <= cmpOn && eqNow;
				end
			end

			// pin level; held wherever no rule moves it
			always @*
			begin
				next_pinLevel = pinLevel;
				if (isModul && !cmpOn)
				begin
					next_pinLevel = 1'b0; // R10
				end
				else if (isModul)
				begin
					// low from match to rollover, high after rollover
					if (matchEvt)
					begin
						next_pinLevel = 1'b0;
					end
					else if (rollNow)
					begin
						next_pinLevel = 1'b1;
					end
				end
				else if (toggleMode && matchEvt)
				begin
					next_pinLevel = ~pinLevel; // R14 R09
				end
			end

			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					pinLevel <= 1'b0;
				end
				else
				begin
					pinLevel <= next_pinLevel;
				end
			end

			// pin released outside output modes so a capture source can drive it
			always @(posedge ref_clk or posedge reset)
			begin
				if (reset)
				begin
					pinOeN <= 1'b1;
				end
				else
				begin
					pinOeN <= ~outMode;
				end
			end

			assign modeFlat[ch*8 +: 8]                 = mode;
			assign ccValue[ch*CNT_WIDTH +: CNT_WIDTH] = ccr;
			assign captureCompareFlag[ch]              = flag;
			assign irqRequest[ch]                      = irq;
			assign modulePinOut[ch]                    = pinLevel;
			// enable is low while the module drives its pin
			assign modulePinOeN[ch]                    = pinOeN;
		end
	endgenerate

endmodule

// [cca_mode_select_monitor.sv]
// assertion checker for the capture/compare mode block, watching module 0
`timescale 1ns/1ns
module cca_mode_select_monitor
(
	// clock and reset
	input wire        ref_clk,
	input wire        reset,
	// register bus
	input wire [7:0]  sfrAddr,
	input wire        sfrWrite,
	input wire        sfrRead,
	input wire [7:0]  sfrWdata,
	input wire [7:0]  sfrRdata,
	// module state
	input wire [15:0] counterValue,
	input wire [79:0] ccValue,
	input wire [4:0]  captureCompareFlag,
	input wire [4:0]  irqRequest,
	input wire [4:0]  modulePinOut,
	input wire [4:0]  modulePinOeN
);
	reg  [7:0] mode;
	wire       hit  = counterValue == ccValue[15:0];
	wire       modu = mode[5:4] == 2'h0 && mode[2:1] == 2'h1;
	wire       tgl  = mode[5:4] == 2'h0 && (mode[3:1] == 3'h6 || mode[3:1] == 3'h3);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// ============================================================
	// mirror of mode register 0
	always @(posedge ref_clk or posedge reset)
		if (reset)
			mode <= 8'h00;
		else if (sfrWrite && sfrAddr == 8'hDA)
			mode <= sfrWdata;
	AST_IRQ: assert property (irqRequest[0] == (captureCompareFlag[0] && $past(mode[0])))
		else $error("irq does not follow flag and enable");
	AST_IRQ_MASK: assert property (!$past(mode[0]) |-> !irqRequest[0])
		else $error("irq while masked");
	AST_MATCH: assert property (mode[6:1] == 6'h24 && hit && !$past(hit)
		|=> captureCompareFlag[0])
		else $error("timer match did not set flag");
	AST_TOGGLE: assert property (mode[6:1] == 6'h26 && hit && !$past(hit)
		|=> modulePinOut[0] != $past(modulePinOut[0]))
		else $error("fast output did not toggle");
	AST_OE: assert property (modulePinOeN[0] == !$past(modu || tgl))
		else $error("pin enable wrong for mode");
	AST_PWM_LOW: assert property ($past(modu && !mode[6]) |-> !modulePinOut[0])
		else $error("modulation with comparator off not low");
	AST_NO_TGL: assert property ($past(tgl && !mode[6]) |-> $stable(modulePinOut[0]))
		else $error("pin moved with comparator off");
	AST_CAPTURE: assert property ($rose(captureCompareFlag[0]) && $past(mode[3:1] == 3'h0)
		|-> ccValue[15:0] == $past(counterValue))
		else $error("capture value wrong");
	AST_READ: assert property (sfrRead && sfrAddr == 8'hDA |=> sfrRdata == $past(mode))
		else $error("mode read back wrong");
	AST_UNMAPPED: assert property (sfrRead && sfrAddr > 8'hDE |=> sfrRdata == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind cca_mode_select cca_mode_select_monitor u_mon (.ref_clk, .reset, .sfrAddr, .sfrWrite,
	.sfrRead, .sfrWdata, .sfrRdata, .counterValue, .ccValue, .captureCompareFlag,
	.irqRequest, .modulePinOut, .modulePinOeN);

// [cca_pin_model.sv]
// far-side model of the module pins
`timescale 1ns/1ns
module cca_pin_model
(
	// from the bench
	input  wire [4:0] pinDrive,
	// from the block
	input  wire [4:0] pinOut,
	input  wire [4:0] pinOeN,
	// wire level seen by the block
	output wire [4:0] pinLevel
);
	// the outside driver yields wherever the block drives its pin
	assign pinLevel = (pinOut & ~pinOeN) | (pinDrive & pinOeN);
endmodule

// [capture_compare_mode_select_tb_top.sv]
// self-checking bench for the capture/compare mode block
`timescale 1ns/1ns
module capture_compare_mode_select_tb_top;
	reg          ref_clk = 0, reset = 1, sfrWrite = 0, sfrRead = 0;
	reg   [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00, d;
	reg   [15:0] counterValue = 16'h0000, ccLoadData = 16'h0000, v;
	reg   [4:0]  ccLoad = 5'h00, flagClear = 5'h00, pinDrive = 5'h00;
	wire  [7:0]  sfrRdata;
	wire  [79:0] ccValue;
	wire  [4:0]  flag, irq, pinOut, oeN, pinLevel;
	int          failures = 0, comparisons = 0, mdl[5], i;
	bit   [31:0] seed = 98499;
	bit   [7:0]  tbl[9] = '{8'h49, 8'h48, 8'h4C, 8'h0C, 8'h47, 8'h4A, 8'hCB, 8'h42, 8'h02};
	logic        p;
	always #4 ref_clk = ~ref_clk;
	cca_mode_select DUT (.ref_clk(ref_clk), .reset(reset), .sfrAddr(sfrAddr),
		.sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.counterValue(counterValue), .ccLoad(ccLoad), .ccLoadData(ccLoadData),
		.ccValue(ccValue), .flagClear(flagClear), .captureCompareFlag(flag),
		.irqRequest(irq), .modulePinIn(pinLevel), .modulePinOut(pinOut), .modulePinOeN(oeN));
	cca_pin_model u_pin (.pinDrive(pinDrive), .pinOut(pinOut), .pinOeN(oeN), .pinLevel(pinLevel));
	// ============================================================
	// helpers
	function bit [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input [7:0] a, input [7:0] w);
		@(negedge ref_clk) {sfrAddr, sfrWdata, sfrWrite} = {a, w, 1'b1};
		@(negedge ref_clk) sfrWrite = 0;
		if (a >= 8'hDA && a <= 8'hDE)
			mdl[a - 8'hDA] = w;
	endtask
	task rd(input [7:0] a);
		@(negedge ref_clk) {sfrAddr, sfrRead} = {a, 1'b1};
		@(negedge ref_clk) sfrRead = 0;
		d = sfrRdata;
	endtask
	// drives the port itself: an output argument would only land at task return
	task clr;
		@(negedge ref_clk) flagClear = 5'h1F;
		@(negedge ref_clk) flagClear = 5'h00;
	endtask
	task summarize;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#(8 * 20000);
		failures++;
		summarize;
	end
	// ============================================================
	// test sequence
	initial
	begin
		repeat (8) @(negedge ref_clk);
		reset = 0;
		for (i = 0; i < 5; i++)
		begin
			rd(8'hDA + i);
			chk(d, 8'h00);
			wr(8'hDA + i, xs());
		end
		for (i = 0; i < 5; i++)
		begin
			rd(8'hDA + i);
			chk(d, mdl[i]);
			wr(8'hDA + i, 8'h00);
		end
		wr(8'hD9, 8'hFF);
		rd(8'hD9);
		chk(d, 8'h00);
		rd(8'hDF);
		chk(d, 8'h00);
		$display("test registers done");
		// capture modes with random don't-care bits on top
		for (i = 0; i < 3; i++)
		begin
			d = (i == 0 ? 8'h20 : i == 1 ? 8'h10 : 8'h30) | (xs() & 8'hC0) | 8'h01;
			wr(8'hDA, d);
			repeat (2)
			begin
				clr;
				counterValue = xs();
				pinDrive[0] = ~pinDrive[0];
				repeat (6) @(negedge ref_clk);
				p = pinDrive[0] ? d[5] : d[4];
				chk(flag[0], p);
				chk(irq[0], p);
				if (p)
					chk(ccValue[15:0], counterValue);
			end
		end
		$display("test capture done");
		// compare modes from the table
		for (i = 0; i < 9; i++)
		begin
			d = tbl[i];
			wr(8'hDA, d);
			v = (xs() & 16'hFF7F) | 16'h0040;
			@(negedge ref_clk) {ccLoadData, ccLoad} = {v, 5'h01};
			@(negedge ref_clk) ccLoad = 0;
			clr;
			p = pinOut[0];
			counterValue = v - 3;
			repeat (8) @(negedge ref_clk) counterValue++;
			chk(flag[0], d[6] & d[3]);
			chk(irq[0], d[6] & d[3] & d[0]);
			chk(oeN[0], !(d[2] | d[1]));
			chk(pinOut[0], (d[1] & !d[2]) ? 1'b0 : p ^ (d[6] & d[2]));
		end
		$display("test compare done");
		summarize;
	end
endmodule
